/* File: hw/lbce_exec.sv */
/*
 * Execution block for the AND, bit clear/set, bit-test-skip and call
 * subset of an 8-bit core.  Holds the accumulator, zero flag, register
 * file, program counter, return stack and the two upper-address buffers.
 * Assumes the fetch logic presents one decoded instruction per cycle with
 * ins_valid, honours ins_ready, and refetches from pc after a call.
 */
// The implementer's own choices: the plain strobed port and the register offsets.
// Behaviour
// RULE1: AND accumulator with register, destination selectable
// RULE2: AND accumulator with immediate into accumulator
// RULE3: Clear chosen register bit, flags untouched
// RULE4: Set chosen register bit, flags untouched
// RULE5: Skip next when tested bit is zero
// RULE6: Skip next when tested bit is one
// RULE7: Skipped slot discards prefetch, runs as no-op
// RULE8: Call pushes counter plus one, two cycles
// RULE9: Immediate call target is buffer and address
// RULE10: Indirect call target is pointer and accumulator
// RULE11: High-address buffer holds call target upper bits
// RULE12: Table-high pointer holds indirect target upper bits
// RULE13: Zero flag follows AND result being zero
// RULE14: Call stores return, then increments stack pointer
`timescale 1ns/10ps
module lbce_exec
   import lbce_pkg::*;
#(
   parameter int STACK_DEPTH = 4            // Return stack entries
)
(
   input  wire logic                  clk_sys,    // Core clock, 125 MHz
   input  wire logic                  rst,        // Synchronous reset
   input  wire logic                  ce,         // Freezes state when low
   input  wire logic                  ins_valid,  // Instruction offered
   input  wire lbce_ins_s             ins,        // Decoded instruction
   output logic                       ins_ready,  // Instruction taken
   output logic                       squash,     // Slot discarded, pulse
   output logic [PC_W-1:0]            pc,         // Program counter
   output logic [DATA_W-1:0]          accumulator,// Accumulator value
   output logic                       zero_flag,  // Zero flag
   output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr, // Return stack ptr
   input  wire logic [BUS_ADDR_W-1:0] bus_addr,   // Software address
   input  wire logic [DATA_W-1:0]     bus_wdata,  // Software write data
   input  wire logic                  bus_wr,     // Write strobe
   input  wire logic                  bus_rd,     // Read strobe
   output logic [DATA_W-1:0]          bus_rdata   // Read data, next cycle
);

   // Pointer wraps: deep nesting overwrites old returns
   localparam int SP_W = $clog2(STACK_DEPTH);

   // Call recognition, used by sequencer, counter and stack
   function automatic logic is_call(input lbce_op_e op);
      is_call = (op == OP_CALL_IMM_OR_ACC);
   endfunction

   // Skip-test recognition
   function automatic logic is_test(input lbce_op_e op);
      is_test = (op == OP_TEST_SKIP_IF_CLEAR) ||
                (op == OP_TEST_SKIP_IF_SET);
   endfunction

   // Architectural state
   logic [DATA_W-1:0]  rf_q [RF_WORDS];        // Register file
   logic [PC_W-1:0]    stack_q [STACK_DEPTH];  // Return addresses
   logic [DATA_W-1:0]  acc_q;                  // Accumulator
   logic [DATA_W-1:0]  acc_d;
   logic               zero_q;                 // Zero flag
   logic               zero_d;
   logic [PC_W-1:0]    pc_q;                   // Program counter
   logic [PC_W-1:0]    pc_d;
   logic [SP_W-1:0]    sp_q;                   // Stack pointer
   logic [SP_W-1:0]    sp_d;
   logic [DATA_W-1:0]  pc_high_buffer_q;               // High-address buffer
   logic [DATA_W-1:0]  pc_high_buffer_d;
   logic [DATA_W-1:0]  tblhi_q;                // Table-high pointer
   logic [DATA_W-1:0]  tblhi_d;

   // Sequencer and output registers
   lbce_state_e        st_q;                   // Sequencer state
   lbce_state_e        st_d;
   logic               ready_q;                // Mirrors next state
   logic               squash_q;               // Discard pulse
   logic [DATA_W-1:0]  rdata_q;                // Read data holder
   logic [DATA_W-1:0]  rdata_d;

   // Decode of the offered instruction
   wire logic          take;                   // Instruction executes
   wire logic          drop;                   // Prefetch discarded
   wire logic [DATA_W-1:0] rval;               // Register operand
   wire logic [DATA_W-1:0] alu_res;            // Logic unit result
   wire logic          alu_zero;               // Result is zero
   wire logic          alu_bit;                // Tested bit value
   wire logic          skip_hit;               // Skip condition met
   wire logic          wr_rf_ins;              // Instruction writes reg
   wire logic          wr_acc_ins;             // Instruction writes acc
   wire logic          upd_zero;               // Instruction sets zero
   wire logic [PC_W-1:0] pc_next;              // Sequential address
   wire logic [PC_W-1:0] call_target;          // Call destination

   // Bus decode
   wire logic          bus_rf_sel;             // Address in reg file
   wire logic [RADDR_W-1:0] bus_rf_idx;        // Register index
   logic [DATA_W-1:0]  bus_rmux;               // Selected read word

   // Operands and the logic unit
   assign rval = rf_q[ins.reg_addr];

   lbce_alu u_alu (
      .acc      (acc_q),
      .rval     (rval),
      .imm      (ins.imm),
      .op       (ins.op),
      .bit_sel  (ins.bit_sel),
      .result   (alu_res),
      .res_zero (alu_zero),
      .bit_val  (alu_bit)
   );

   // Handshake: a slot after a skip is consumed but not executed
   assign take = ce && ins_valid && (st_q == ST_RUN);
   // A word offered while skipping is eaten, never run
   assign drop = ce && ins_valid && (st_q == ST_SKIP);   // RULE7

   // Skip when the bit matches the flavour of the test
   assign skip_hit =
      ((ins.op == OP_TEST_SKIP_IF_CLEAR) && !alu_bit) ||  // RULE5
      ((ins.op == OP_TEST_SKIP_IF_SET)   &&  alu_bit);    // RULE6

   // Where each operation writes; tests and calls leave the flag alone
   assign wr_rf_ins  = take &&
      (((ins.op == OP_AND_ACC_REG) && ins.dest_reg) ||    // RULE1
       (ins.op == OP_BIT_CLEAR_REG) ||                    // RULE3
       (ins.op == OP_BIT_SET_REG));                       // RULE4
   assign wr_acc_ins = take &&
      (((ins.op == OP_AND_ACC_REG) && !ins.dest_reg) ||   // RULE1
       (ins.op == OP_AND_ACC_IMM));                       // RULE2
   assign upd_zero   = take &&
      ((ins.op == OP_AND_ACC_REG) ||
       (ins.op == OP_AND_ACC_IMM));                       // RULE13

   // Return address and call destination
   assign pc_next     = pc_q + 10'h001;                     // RULE8
   assign call_target = ins.via_acc ?
      {tblhi_q[PCH_W-1:0], acc_q} :                         // RULE10
      {pc_high_buffer_q[PCH_W-1:0], ins.imm};                       // RULE9

   // Sequencer: calls burn one dead slot, taken skips squash one slot
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_RUN: begin
            // Call checked first; an op is never both
            if (take && is_call(ins.op)) begin
               st_d = ST_CALL2;                           // RULE8
            end else if (take && is_test(ins.op) && skip_hit) begin
               st_d = ST_SKIP;                            // RULE5 RULE6
            end
         end
         ST_SKIP: begin
            // Wait until the prefetched word arrives to throw it away
            if (drop) begin
               st_d = ST_RUN;                             // RULE7
            end
         end
         ST_CALL2: begin
            // Second call cycle; fetch restarts from the new target
            if (ce) begin
               st_d = ST_RUN;
            end
         end
         default: begin
            st_d = ST_RUN;
         end
      endcase
   end

   // Counter, stack pointer
   always_comb begin
      pc_d = pc_q;
      sp_d = sp_q;
      if (take && is_call(ins.op)) begin
         // Jump and push land on the same edge
         pc_d = call_target;                       // RULE9 RULE10
         sp_d = sp_q + 1'b1;                       // RULE14
      end else if (take || drop) begin
         // The squashed slot still advances past its own address
         pc_d = pc_next;
      end
   end

   // Accumulator and zero flag; instruction beats a software write
   always_comb begin
      acc_d  = acc_q;
      zero_d = zero_q;
      if (ce && bus_wr && (bus_addr == OFS_ACC)) begin
         acc_d = bus_wdata;
      end
      if (ce && bus_wr && (bus_addr == OFS_STATUS)) begin
         zero_d = bus_wdata[STAT_ZERO_BIT];
      end
      // Later assignment: the core wins over software
      if (wr_acc_ins) begin
         acc_d = alu_res;                          // RULE1 RULE2
      end
      if (upd_zero) begin
         zero_d = alu_zero;                        // RULE13
      end
   end

   // Upper-address buffers are software loaded only
   always_comb begin
      pc_high_buffer_d = pc_high_buffer_q;
      tblhi_d  = tblhi_q;
      if (ce && bus_wr && (bus_addr == OFS_PC_HIGH_BUFFER)) begin
         pc_high_buffer_d = bus_wdata;                     // RULE11
      end
      if (ce && bus_wr && (bus_addr == OFS_TBLHI)) begin
         tblhi_d = bus_wdata;                      // RULE12
      end
   end

   // Sequencer and handshake outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q     <= ST_RUN;
         ready_q  <= 1'b1;
         squash_q <= 1'b0;
      end else if (ce) begin
         st_q     <= st_d;
         // Ready is low only in the dead call slot
         ready_q  <= (st_d != ST_CALL2);   // RULE8
         squash_q <= drop;                 // RULE7
      end
   end

   // Program counter and stack pointer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pc_q <= PC_RST;
         sp_q <= '0;
      end else if (ce) begin
         pc_q <= pc_d;
         sp_q <= sp_d;
      end
   end

   // Accumulator and zero flag
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc_q  <= ACC_RST;
         zero_q <= ZERO_RST;
      end else if (ce) begin
         acc_q  <= acc_d;
         zero_q <= zero_d;
      end
   end

   // Upper-address buffers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pc_high_buffer_q <= BUF_RST;
         tblhi_q  <= BUF_RST;
      end else if (ce) begin
         pc_high_buffer_q <= pc_high_buffer_d;
         tblhi_q  <= tblhi_d;
      end
   end

   // Return stack: entry under the old pointer takes the return address
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_q[i] <= PC_RST;
         end
      end else if (take && is_call(ins.op)) begin
         stack_q[sp_q] <= pc_next;                 // RULE8 RULE14
      end
   end

   // Register file; an instruction write lands after a bus write so the
   // core wins a same-cycle collision on one location
   assign bus_rf_sel = (bus_addr <= OFS_RF_LAST);
   assign bus_rf_idx = bus_addr[RADDR_W-1:0];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < RF_WORDS; i++) begin
            rf_q[i] <= RF_RST;
         end
      end else if (ce) begin
         if (bus_wr && bus_rf_sel) begin
            rf_q[bus_rf_idx] <= bus_wdata;
         end
         if (wr_rf_ins) begin
            rf_q[ins.reg_addr] <= alu_res;         // RULE1 RULE3 RULE4
         end
      end
   end

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      bus_rmux = 8'h00;
      if (bus_rf_sel) begin
         bus_rmux = rf_q[bus_rf_idx];
      end else begin
         unique case (bus_addr)
            OFS_ACC:    bus_rmux = acc_q;
            OFS_STATUS: bus_rmux[STAT_ZERO_BIT] = zero_q;
            OFS_PC_HIGH_BUFFER: bus_rmux = pc_high_buffer_q;
            OFS_TBLHI:  bus_rmux = tblhi_q;
            OFS_PC_LO:  bus_rmux = pc_q[PCH_LSB-1:0];
            // Read-only view of pc[9:8] and the pointer
            OFS_PC_HI: begin
               bus_rmux[PCH_W-1:0] = pc_q[PC_W-1:PCH_LSB];
               bus_rmux[PCHI_SP_LSB +: SP_W] = sp_q;
            end
            default:    bus_rmux = 8'h00;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   // Zero elsewhere, so idle cycles never echo stale data
   assign rdata_d = bus_rd ? bus_rmux : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (ce) begin
         rdata_q <= rdata_d;
      end
   end

   // Outputs straight from flip-flops
   assign ins_ready   = ready_q;
   assign squash      = squash_q;
   assign pc          = pc_q;
   assign accumulator = acc_q;
   assign zero_flag   = zero_q;
   assign stack_ptr   = sp_q;
   assign bus_rdata   = rdata_q;

endmodule

/* File: hw/lbce_pkg.sv */
/*
 * Shared constants and types for the logic, bit and call execution block:
 * widths, register offsets, reset values, operation codes and the
 * instruction carrier.
 * Assumes a single core clock and a decoder upstream that fills lbce_ins_s.
 */
package lbce_pkg;

   // Datapath widths
   localparam int DATA_W     = 8;   // Accumulator and register width
   localparam int RADDR_W    = 6;   // Register-file address, 0..63
   localparam int RF_WORDS   = 64;  // Register-file depth
   localparam int BITSEL_W   = 3;   // Bit position, 0..7
   localparam int PC_W       = 10;  // Program counter width
   localparam int PCH_LSB    = 8;   // First upper bit of the counter
   localparam int PCH_W      = 2;   // Upper bits taken from a buffer
   localparam int BUS_ADDR_W = 8;   // Software port address width

   // Software port offsets
   localparam logic [7:0] OFS_RF_LAST = 8'h3F; // 0x00..0x3F register file
   localparam logic [7:0] OFS_ACC     = 8'h40; // Accumulator
   localparam logic [7:0] OFS_STATUS  = 8'h41; // Bit 0 zero flag
   localparam logic [7:0] OFS_PC_HIGH_BUFFER  = 8'h42; // High-address buffer
   localparam logic [7:0] OFS_TBLHI   = 8'h43; // Table-high pointer
   localparam logic [7:0] OFS_PC_LO   = 8'h44; // Counter bits 7..0, RO
   localparam logic [7:0] OFS_PC_HI   = 8'h45; // {sp, counter 9..8}, RO

   // Status field positions
   localparam int STAT_ZERO_BIT = 0;   // Zero flag in the status word
   localparam int PCHI_SP_LSB   = 4;   // Stack pointer in the high word

   // Reset values
   localparam logic [7:0]      ACC_RST  = 8'h00;
   localparam logic [7:0]      BUF_RST  = 8'h00;
   localparam logic [7:0]      RF_RST   = 8'h00;
   localparam logic [9:0]      PC_RST   = 10'h000;
   localparam logic            ZERO_RST = 1'b0;

   // Cycle counts of the multi-cycle operations
   localparam int CALL_CYCLES = 2;   // Call plus its dead fetch slot
   localparam int SKIP_CYCLES = 2;   // Test plus the squashed slot

   // Operations handled here
   typedef enum logic [2:0] {
      OP_NOP                  = 3'h0,
      OP_AND_ACC_REG          = 3'h1,
      OP_AND_ACC_IMM          = 3'h2,
      OP_BIT_CLEAR_REG        = 3'h3,
      OP_BIT_SET_REG          = 3'h4,
      OP_TEST_SKIP_IF_CLEAR   = 3'h5,
      OP_TEST_SKIP_IF_SET     = 3'h6,
      OP_CALL_IMM_OR_ACC      = 3'h7
   } lbce_op_e;

   // One decoded instruction
   typedef struct packed {
      lbce_op_e              op;       // Operation
      logic [RADDR_W-1:0]    reg_addr; // Register operand
      logic [BITSEL_W-1:0]   bit_sel;  // Bit position
      logic                  dest_reg; // 1: result to register
      logic                  via_acc;  // Call target from accumulator
      logic [DATA_W-1:0]     imm;      // Immediate data or address
   } lbce_ins_s;

   // Execution sequencer states
   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_SKIP  = 3'b010,
      ST_CALL2 = 3'b100
   } lbce_state_e;

endpackage

/* File: hw/lbce_alu.sv */
/*
 * Combinational logic unit: AND, single-bit clear and set, bit test.
 * Assumes operands are stable for the whole cycle; no state inside.
 */
`timescale 1ns/10ps
module lbce_alu
   import lbce_pkg::*;
(
   input  wire logic [DATA_W-1:0]   acc,
   input  wire logic [DATA_W-1:0]   rval,
   input  wire logic [DATA_W-1:0]   imm,
   input  wire lbce_op_e            op,
   input  wire logic [BITSEL_W-1:0] bit_sel,
   output logic      [DATA_W-1:0]   result,
   output logic                     res_zero,
   output logic                     bit_val
);

   // One-hot mask of the selected bit
   wire logic [DATA_W-1:0] bit_mask;
   assign bit_mask = 8'h01 << bit_sel;

   // Result selection by operation
   always_comb begin
      unique case (op)
         OP_AND_ACC_REG:   result = acc & rval;        // RULE1
         OP_AND_ACC_IMM:   result = acc & imm;         // RULE2
         OP_BIT_CLEAR_REG: result = rval & ~bit_mask;  // RULE3
         OP_BIT_SET_REG:   result = rval | bit_mask;   // RULE4
         default:          result = rval;
      endcase
   end

   // Zero when every result bit is low
   assign res_zero = (result == 8'h00);  // RULE13
   // Selected register bit for the skip tests
   assign bit_val  = rval[bit_sel];

endmodule

/* File: verification/lbce_exec_properties.sv */
/*
 * Port-level checker for the execution block: AND results, flag
 * behaviour, skip squash and call sequencing.
 * Assumes one clock domain and is bound to every lbce_exec instance.
 */
`timescale 1ns/10ps
module lbce_exec_chk
   import lbce_pkg::*;
#(
   parameter int STACK_DEPTH = 4   // Return stack entries
)
(
   input wire logic                          clk_sys,
   input wire logic                          rst,
   input wire logic                          ce,
   input wire logic                          ins_valid,
   input wire lbce_ins_s                     ins,
   input wire logic                          ins_ready,
   input wire logic                          squash,
   input wire logic [PC_W-1:0]               pc,
   input wire logic [DATA_W-1:0]             accumulator,
   input wire logic                          zero_flag,
   input wire logic [$clog2(STACK_DEPTH)-1:0] stack_ptr,
   input wire logic [BUS_ADDR_W-1:0]         bus_addr,
   input wire logic [DATA_W-1:0]             bus_wdata,
   input wire logic                          bus_wr,
   input wire logic                          bus_rd,
   input wire logic [DATA_W-1:0]             bus_rdata
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Instruction accepted; a squashed slot is also accepted, hence the
   // squash escape in the result checks below
   wire take     = ce && ins_valid && ins_ready;
   wire take_and = take && !bus_wr && ins.op == OP_AND_ACC_IMM;
   wire take_cal = take && ins.op == OP_CALL_IMM_OR_ACC;

   a_and_imm_acc: assert property (take_and |=> squash ||
      accumulator == ($past(accumulator) & $past(ins.imm)))
      else $error("immediate AND gave a wrong accumulator");
   a_and_zero_flag: assert property (take_and |=> squash ||
      zero_flag == (($past(accumulator) & $past(ins.imm)) == 8'h00))
      else $error("zero flag does not follow the AND result");
   a_reg_dest_acc: assert property (take && !bus_wr &&
      ins.op == OP_AND_ACC_REG && ins.dest_reg |=> $stable(accumulator))
      else $error("register-destination AND touched the accumulator");
   a_bit_ops_flags: assert property (take && !bus_wr &&
      ins.op inside {OP_BIT_CLEAR_REG, OP_BIT_SET_REG, OP_TEST_SKIP_IF_CLEAR,
      OP_TEST_SKIP_IF_SET} |=> $stable(zero_flag) && $stable(accumulator))
      else $error("bit operation altered the flag or accumulator");
   a_call_two_cyc: assert property (take_cal |=> squash or
      (!ins_ready ##1 (ins_ready || !$past(ce))))
      else $error("call did not hold off exactly one cycle");
   a_call_push_sp: assert property (take_cal |=>
      squash || stack_ptr == $past(stack_ptr) + 1'b1)
      else $error("call did not advance the stack pointer");
   a_call_imm_low: assert property (take_cal && !ins.via_acc |=>
      squash || pc[7:0] == $past(ins.imm))
      else $error("immediate call low target wrong");
   a_call_acc_low: assert property (take_cal && ins.via_acc |=>
      squash || pc[7:0] == $past(accumulator))
      else $error("indirect call low target wrong");
   a_pc_step_one: assert property (take && !take_cal |=>
      pc == $past(pc) + 1'b1)
      else $error("counter did not step by one");
   a_squash_pulse: assert property (squash |=> !squash)
      else $error("squash longer than one cycle");
endmodule

bind lbce_exec lbce_exec_chk #(.STACK_DEPTH(STACK_DEPTH)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .ce(ce), .ins_valid(ins_valid),
   .ins(ins), .ins_ready(ins_ready), .squash(squash), .pc(pc),
   .accumulator(accumulator), .zero_flag(zero_flag),
   .stack_ptr(stack_ptr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

/* File: verification/tb_logic_bit_call_exec.sv */
/*
 * Self-checking bench for the execution block: register port, AND,
 * bit clear/set, test-and-skip and both call forms.
 * Assumes the hand-over timing: one instruction per handshake, read
 * data in the cycle after the read strobe.
 */
`timescale 1ns/10ps
module tb_logic_bit_call_exec
   import lbce_pkg::*;
();
   logic            clk_sys = 1'b0;  // 125 MHz core clock
   logic            rst;             // Synchronous reset
   logic            ce;              // Kept high: freezing is not a rule
   logic            ins_valid;       // Instruction offered
   lbce_ins_s       ins;             // Decoded instruction
   logic            ins_ready;       // Instruction taken
   logic            squash;          // Dropped slot pulse
   logic [9:0]      pc;              // Program counter
   logic [7:0]      accumulator;     // Accumulator
   logic            zero_flag;       // Zero flag
   logic [1:0]      stack_ptr;       // Return stack pointer
   logic [7:0]      bus_addr;        // Software address
   logic [7:0]      bus_wdata;       // Software write data
   logic            bus_wr;          // Write strobe
   logic            bus_rd;          // Read strobe
   logic [7:0]      bus_rdata;       // Read data
   int              n_mismatch = 0;  // Failed comparisons
   int              total_checks = 0; // All comparisons
   int              cyc = 0;         // Cycle count for the hang guard

   lbce_exec #(.STACK_DEPTH(4)) dut (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .ins_valid(ins_valid),
      .ins(ins), .ins_ready(ins_ready), .squash(squash), .pc(pc),
      .accumulator(accumulator), .zero_flag(zero_flag),
      .stack_ptr(stack_ptr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

   // Free-running clock, 8 ns period
   always #4 clk_sys = ~clk_sys;

   // Report and stop; the only place the run ends
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard: the tests need well under 300 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch = n_mismatch + 1;
         give_verdict();
      end
   end

   // Value comparison with four-state equality
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge clk_sys);
      bus_wr    <= 1'b0;
   endtask

   // One-cycle read strobe; data is looked at only in the next cycle
   task automatic rchk(input string what, input logic [7:0] a,
                       input logic [7:0] exp);
      @(posedge clk_sys);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk_sys);
      bus_rd   <= 1'b0;
      #1;
      chk(what, 16'(exp), 16'(bus_rdata));
   endtask

   // Offer one instruction for one cycle, then settle past the edge
   task automatic exec(input lbce_op_e op, input logic [5:0] ra,
                       input logic [2:0] bs, input logic d,
                       input logic va, input logic [7:0] im);
      @(posedge clk_sys);
      ins_valid <= 1'b1;
      ins       <= '{op, ra, bs, d, va, im};
      @(posedge clk_sys);
      ins_valid <= 1'b0;
      #1;
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      ins_valid = 1'b0;
      ins = '0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk("reset state", 16'h0004,
          {pc, zero_flag, stack_ptr, ins_ready, squash, |bus_rdata});
      chk("reset acc", 16'(ACC_RST), 16'(accumulator));
      // Register port, read-only and unmapped places
      wr(8'h05, 8'hAF);
      wr(OFS_ACC, 8'h5A);
      rchk("rf5", 8'h05, 8'hAF);
      rchk("acc", OFS_ACC, 8'h5A);
      rchk("unmapped", 8'h46, 8'h00);
      wr(OFS_PC_LO, 8'hFF);
      rchk("pc lo ro", OFS_PC_LO, 8'h00);
      $display("Test registers done");
      // AND forms: both destinations, then a zero result
      exec(OP_AND_ACC_REG, 6'h05, 3'h0, 1'b1, 1'b0, 8'h00);
      rchk("rf5 and", 8'h05, 8'h0A);
      chk("acc kept", 16'h005A, 16'(accumulator));
      exec(OP_AND_ACC_REG, 6'h05, 3'h0, 1'b0, 1'b0, 8'h00);
      chk("acc and", 16'h000A, 16'(accumulator));
      chk("zero clear", 16'h0000, 16'(zero_flag));
      exec(OP_AND_ACC_IMM, 6'h00, 3'h0, 1'b0, 1'b0, 8'hA5);
      chk("acc imm", 16'h0000, 16'(accumulator));
      chk("zero set", 16'h0001, 16'(zero_flag));
      chk("pc and", 16'h0003, 16'(pc));
      $display("Test and done");
      // Single-bit clear and set
      wr(8'h07, 8'h5A);
      exec(OP_BIT_CLEAR_REG, 6'h07, 3'h3, 1'b0, 1'b0, 8'h00);
      rchk("bit clear", 8'h07, 8'h52);
      exec(OP_BIT_SET_REG, 6'h07, 3'h2, 1'b0, 1'b0, 8'h00);
      rchk("bit set", 8'h07, 8'h56);
      chk("zero held", 16'h0001, 16'(zero_flag));
      $display("Test bits done");
      // Skips taken and not taken; dropped slots would change rf7
      exec(OP_TEST_SKIP_IF_CLEAR, 6'h07, 3'h0, 1'b0, 1'b0, 8'h00);
      exec(OP_BIT_SET_REG, 6'h07, 3'h0, 1'b0, 1'b0, 8'h00);
      chk("squash clr", 16'h0001, 16'(squash));
      rchk("slot dropped", 8'h07, 8'h56);
      exec(OP_TEST_SKIP_IF_SET, 6'h07, 3'h0, 1'b0, 1'b0, 8'h00);
      exec(OP_BIT_SET_REG, 6'h07, 3'h7, 1'b0, 1'b0, 8'h00);
      chk("no squash", 16'h0000, 16'(squash));
      rchk("slot ran", 8'h07, 8'hD6);
      exec(OP_TEST_SKIP_IF_SET, 6'h07, 3'h7, 1'b0, 1'b0, 8'h00);
      exec(OP_BIT_CLEAR_REG, 6'h07, 3'h7, 1'b0, 1'b0, 8'h00);
      chk("squash set", 16'h0001, 16'(squash));
      rchk("slot dropped", 8'h07, 8'hD6);
      exec(OP_TEST_SKIP_IF_CLEAR, 6'h07, 3'h1, 1'b0, 1'b0, 8'h00);
      exec(OP_BIT_CLEAR_REG, 6'h07, 3'h1, 1'b0, 1'b0, 8'h00);
      rchk("slot ran", 8'h07, 8'hD4);
      chk("pc skip", 16'h000D, 16'(pc));
      chk("zero skip", 16'h0001, 16'(zero_flag));
      $display("Test skip done");
      // Immediate call; only the two low buffer bits reach the counter
      wr(OFS_PC_HIGH_BUFFER, 8'h06);
      rchk("pc high buf", OFS_PC_HIGH_BUFFER, 8'h06);
      exec(OP_CALL_IMM_OR_ACC, 6'h00, 3'h0, 1'b0, 1'b0, 8'h80);
      chk("ready low", 16'h0000, 16'(ins_ready));
      chk("pc call", 16'h0280, 16'(pc));
      chk("sp call", 16'h0001, 16'(stack_ptr));
      rchk("pc hi sp", OFS_PC_HI, 8'h12);
      // Indirect call with a word offered in the held-off cycle
      wr(OFS_TBLHI, 8'h02);
      wr(OFS_ACC, 8'h34);
      @(posedge clk_sys);
      ins_valid <= 1'b1;
      ins       <= '{OP_CALL_IMM_OR_ACC, 6'h00, 3'h0, 1'b0, 1'b1, 8'h00};
      @(posedge clk_sys);
      ins       <= '{OP_AND_ACC_IMM, 6'h00, 3'h0, 1'b0, 1'b0, 8'h00};
      @(posedge clk_sys);
      ins_valid <= 1'b0;
      #1;
      chk("pc call_via_accumulator", 16'h0234, 16'(pc));
      chk("acc refused", 16'h0034, 16'(accumulator));
      chk("sp call_via_accumulator", 16'h0002, 16'(stack_ptr));
      chk("ready back", 16'h0001, 16'(ins_ready));
      $display("Test call done");
      give_verdict();
   end
endmodule
